// ---- logic/pic_ctrl.sv ----
// pi process controller producing the drive speed demand
`timescale 1ns/100ps
module pic_ctrl
  import pic_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC          // control loop period in clocks
)
(
  input  wire logic        core_clk,                  // 100 MHz clock
  input  wire logic        resetn,                    // async reset, active low
  input  wire logic [9:0]  ain1_level,                // analog input 1, 0.1 % units
  input  wire logic [9:0]  ain2_level,                // analog input 2, 0.1 % units
  input  wire logic [11:0] motor_current,             // measured current, 0.1 A
  input  wire logic [11:0] motor_rated_current,       // rated current, 0.1 A
  input  wire logic [10:0] dc_bus_volts,              // dc bus voltage, 1 V
  input  wire logic [15:0] fieldbus_process_word_two, // bus setpoint, 0.1 % units
  input  wire logic        settings_load,             // pulse: take the settings below
  input  wire logic [8:0]  pi_gain,                   // proportional gain, 0.1 units
  input  wire logic [8:0]  pi_integral_time,          // integral time, 0.1 s
  input  wire logic [1:0]  pi_mode,                   // 0..3 operating mode
  input  wire logic [1:0]  sp_source,                 // setpoint source
  input  wire logic [9:0]  digital_preset,            // preset setpoint, 0.1 %
  input  wire logic [2:0]  fb_source,                 // feedback source
  input  wire logic [7:0]  standby_time,              // standby timer, 0.1 s
  input  wire logic [9:0]  wake_level,                // wake error level, 0.1 %
  input  wire logic        at_min_speed,              // drive runs at minimum speed
  output logic      [9:0]  speed_demand,              // controller output, 0.1 %
  output logic             motor_enable,              // motor output allowed
  output logic             standby,                   // drive in standby
  output logic      [9:0]  feedback_level,            // selected feedback, 0.1 %
  output logic      [9:0]  ain1_level_readout,        // analog input 1 readout
  output logic      [9:0]  ain2_level_readout         // analog input 2 readout
);
  // ************************************************************
  // settings, clamped to their ranges on load
  // ************************************************************
  logic [8:0]  gain_ff, nxt_gain;
  logic [8:0]  ti_ff, nxt_ti;
  logic [1:0]  mode_ff, nxt_mode;
  logic [1:0]  sps_ff, nxt_sps;
  logic [9:0]  preset_ff, nxt_preset;
  logic [2:0]  fbs_ff, nxt_fbs;
  logic [7:0]  stby_ff, nxt_stby;
  logic [9:0]  wake_ff, nxt_wake;

  always_comb
  begin
    nxt_gain   = gain_ff;
    nxt_ti     = ti_ff;
    nxt_mode   = mode_ff;
    nxt_sps    = sps_ff;
    nxt_preset = preset_ff;
    nxt_fbs    = fbs_ff;
    nxt_stby   = stby_ff;
    nxt_wake   = wake_ff;
    if (settings_load)
    begin
      nxt_gain   = (pi_gain > GAIN_MAX) ? GAIN_MAX : pi_gain;
      nxt_ti     = (pi_integral_time > TI_MAX) ? TI_MAX : pi_integral_time;
      nxt_mode   = pi_mode;
      // unknown setpoint source codes fall back to the preset, unknown feedback codes to FB_AIN2
      nxt_sps    = (sp_source > SP_BUS) ? SP_PRESET : sp_source;
      nxt_preset = (digital_preset > PCT_FULL) ? PCT_FULL : digital_preset;
      nxt_fbs    = (fb_source > FB_LARGER) ? FB_AIN2 : fb_source;
      nxt_stby   = (standby_time > STBY_MAX) ? STBY_MAX : standby_time;
      nxt_wake   = (wake_level > PCT_FULL) ? PCT_FULL : wake_level;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gain_ff   <= GAIN_RST;
      ti_ff     <= TI_RST;
      mode_ff   <= 2'h0;
      sps_ff    <= SP_PRESET;
      preset_ff <= PRESET_RST;
      fbs_ff    <= FB_AIN2;
      stby_ff   <= 8'h00;
      wake_ff   <= WAKE_RST;
    end
    else
    begin
      gain_ff   <= nxt_gain;
      ti_ff     <= nxt_ti;
      mode_ff   <= nxt_mode;
      sps_ff    <= nxt_sps;
      preset_ff <= nxt_preset;
      fbs_ff    <= nxt_fbs;
      stby_ff   <= nxt_stby;
      wake_ff   <= nxt_wake;
    end
  end

  // ************************************************************
  // feedback selection
  // ************************************************************
  pic_fb_if fbi ();
  assign fbi.ain1     = ain1_level;
  assign fbi.ain2     = ain2_level;
  assign fbi.current  = motor_current;
  assign fbi.rated    = motor_rated_current;
  assign fbi.dc_volts = dc_bus_volts;
  assign fbi.sel      = fbs_ff;

  pic_feedback u_fb (
    .core_clk (core_clk),
    .resetn   (resetn),
    .fbi      (fbi)
  );

  // ************************************************************
  // loop: sample tick, error, pi law, standby
  // ************************************************************
  localparam int TICK_W = $clog2(SAMPLE_CYCLES + 1);

  pic_state_t          state_ff, nxt_state;
  logic [TICK_W-1:0]   tick_cnt_ff, nxt_tick_cnt;
  logic [14:0]         stby_cnt_ff, nxt_stby_cnt;
  logic signed [31:0]  integ_ff, nxt_integ;
  logic [9:0]          demand_ff, nxt_demand;
  logic [9:0]          sp_ff, nxt_sp;
  logic [9:0]          rd1_ff, rd2_ff;
  logic                tick;
  logic                run_ff, nxt_run;
  logic                standby_ff, nxt_standby;
  logic signed [31:0]  err, kp_err, p_term, incr, sum, integ_full;
  logic [15:0]         stby_target;

  assign integ_full  = 32'(PCT_FULL) <<< INT_FRAC;
  assign stby_target = 16'(stby_ff) * 16'(MS_PER_TENTH);

  always_comb
  begin
    tick         = (tick_cnt_ff == TICK_W'(SAMPLE_CYCLES - 1));
    nxt_tick_cnt = tick ? '0 : TICK_W'(tick_cnt_ff + 1'b1);
    case (sps_ff)
      SP_PRESET: nxt_sp = preset_ff;
      SP_AIN1:   nxt_sp = ain1_level;
      // bus word is trusted only up to full scale
      SP_BUS:    nxt_sp = (fieldbus_process_word_two > 16'(PCT_FULL)) ? PCT_FULL
                          : fieldbus_process_word_two[9:0];
      default:   nxt_sp = preset_ff;
    endcase
    // inverse modes turn the error round
    err    = mode_ff[0] ? (32'(fbi.fb) - 32'(sp_ff)) : (32'(sp_ff) - 32'(fbi.fb));
    // every operand signed, or a negative error would be read as a huge positive one
    kp_err = err * $signed(32'(gain_ff));
    p_term = kp_err / 32'sd10;
    // zero integral time disables integration
    incr   = (ti_ff == 9'h000) ? 32'sd0
             : (kp_err <<< INT_FRAC) / ($signed(32'(ti_ff)) * 32'sd1000);
    sum    = p_term + (integ_ff >>> INT_FRAC);
    nxt_state    = state_ff;
    nxt_stby_cnt = stby_cnt_ff;
    nxt_integ    = integ_ff;
    nxt_demand   = demand_ff;
    case (state_ff)
      ST_RUN:
      begin
        if (tick)
        begin
          if (sum >= $signed(32'(PCT_FULL)))
          begin
            nxt_demand = PCT_FULL;
            if (incr < 0) nxt_integ = integ_ff + incr;
          end
          else if (sum <= 0)
          begin
            nxt_demand = 10'h000;
            if (incr > 0) nxt_integ = integ_ff + incr;
          end
          else
          begin
            nxt_demand = sum[9:0];
            nxt_integ  = integ_ff + incr;
          end
          if (nxt_integ > integ_full) nxt_integ = integ_full;
          if (nxt_integ < 0) nxt_integ = 32'sd0;
          if (stby_ff != 8'h00 && at_min_speed)
          begin
            nxt_stby_cnt = 15'(stby_cnt_ff + 1'b1);
            if (16'(nxt_stby_cnt) >= stby_target)
            begin
              nxt_state = ST_STANDBY;
            end
          end
          else
          begin
            nxt_stby_cnt = 15'h0000;
          end
        end
      end
      ST_STANDBY:
      begin
        nxt_stby_cnt = 15'h0000;
        if (tick && err > $signed(32'(wake_ff)))
        begin
          nxt_state = ST_RUN;
          if (mode_ff[1])
          begin
            nxt_demand = PCT_FULL;
            nxt_integ  = integ_full;
          end
        end
      end
      default:
      begin
        nxt_state = ST_RUN;
      end
    endcase
    nxt_run     = (nxt_state == ST_RUN);
    nxt_standby = (nxt_state == ST_STANDBY);
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff    <= ST_RUN;
      tick_cnt_ff <= '0;
      stby_cnt_ff <= 15'h0000;
      integ_ff    <= 32'sd0;
      demand_ff   <= 10'h000;
      sp_ff       <= 10'h000;
      rd1_ff      <= 10'h000;
      rd2_ff      <= 10'h000;
    end
    else
    begin
      state_ff    <= nxt_state;
      tick_cnt_ff <= nxt_tick_cnt;
      stby_cnt_ff <= nxt_stby_cnt;
      integ_ff    <= nxt_integ;
      demand_ff   <= nxt_demand;
      sp_ff       <= nxt_sp;
      rd1_ff      <= ain1_level;
      rd2_ff      <= ain2_level;
    end
  end

  // state decodes get flops of their own so the pins carry no decode glitches
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      run_ff     <= 1'b1;
      standby_ff <= 1'b0;
    end
    else
    begin
      run_ff     <= nxt_run;
      standby_ff <= nxt_standby;
    end
  end

  assign speed_demand       = demand_ff;
  assign motor_enable       = run_ff;
  assign standby            = standby_ff;
  assign feedback_level     = fbi.fb;
  assign ain1_level_readout = rd1_ff;
  assign ain2_level_readout = rd2_ff;
endmodule

// ---- logic/pic_pkg.sv ----
// shared constants and types for the process controller
package pic_pkg;
  // ************************************************************
  // fixed-point scale: all levels in tenths of a percent
  // ************************************************************
  localparam int          LVL_W        = 10;
  localparam logic [9:0]  PCT_FULL     = 10'h3E8;   // 100.0 %
  localparam int          INT_FRAC     = 10;        // integrator fraction bits
  // ************************************************************
  // setting limits and reset defaults
  // ************************************************************
  localparam logic [8:0]  GAIN_MAX     = 9'h12C;    // 30.0
  localparam logic [8:0]  GAIN_RST     = 9'h00A;    // 1.0
  localparam logic [8:0]  TI_MAX       = 9'h12C;    // 30.0 s
  localparam logic [8:0]  TI_RST       = 9'h00A;    // 1.0 s
  localparam logic [7:0]  STBY_MAX     = 8'hFA;     // 25.0 s
  localparam logic [9:0]  WAKE_RST     = 10'h032;   // 5.0 %
  localparam logic [9:0]  PRESET_RST   = 10'h000;   // 0.0 %
  localparam logic [10:0] DCV_FULL     = 11'h3E8;   // 1000 V
  // ************************************************************
  // timing
  // ************************************************************
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          SAMPLE_NS     = 1000000;  // 1 ms loop period
  localparam int          SAMPLE_CYC    = SAMPLE_NS / CLK_PERIOD_NS;
  localparam int          MS_PER_TENTH  = 100;      // standby timer unit 0.1 s
  // ************************************************************
  // selector codes
  // ************************************************************
  typedef enum logic [1:0] {
    SP_PRESET  = 2'h0,
    SP_AIN1    = 2'h1,
    SP_BUS     = 2'h2
  } pic_sp_src_t;
  typedef enum logic [2:0] {
    FB_AIN2    = 3'h0,
    FB_AIN1    = 3'h1,
    FB_CURRENT = 3'h2,
    FB_DCBUS   = 3'h3,
    FB_DIFF    = 3'h4,
    FB_LARGER  = 3'h5
  } pic_fb_src_t;
  typedef enum logic [1:0] {
    ST_RUN     = 2'h0,
    ST_STANDBY = 2'h1
  } pic_state_t;
endpackage

// ---- logic/pic_fb_if.sv ----
// carrier between the controller core and its feedback selector
`timescale 1ns/100ps
interface pic_fb_if;
  logic [9:0]  ain1;
  logic [9:0]  ain2;
  logic [11:0] current;
  logic [11:0] rated;
  logic [10:0] dc_volts;
  logic [2:0]  sel;
  logic [9:0]  fb;
  modport ctrl (output ain1, ain2, current, rated, dc_volts, sel, input fb);
  modport fbk  (input ain1, ain2, current, rated, dc_volts, sel, output fb);
endinterface

// ---- logic/pic_feedback.sv ----
// feedback source selection and normalisation to tenths of a percent
`timescale 1ns/100ps
module pic_feedback
  import pic_pkg::*;
(
  input  wire logic core_clk,   // system clock
  input  wire logic resetn,     // async reset, active low
  pic_fb_if.fbk     fbi         // source levels in, feedback out
);
  logic [9:0]  fb_ff;
  logic [9:0]  nxt_fb;
  logic [23:0] cur_scaled;
  logic [23:0] cur_pct;

  always_comb
  begin
    cur_scaled = 24'(fbi.current) * 24'(PCT_FULL);
    // a zero rated current would divide by zero; treat as no feedback
    cur_pct    = (fbi.rated == 12'h000) ? 24'h000000 : cur_scaled / 24'(fbi.rated);
    case (fbi.sel)
      FB_AIN2:    nxt_fb = fbi.ain2;
      FB_AIN1:    nxt_fb = fbi.ain1;
      FB_CURRENT: nxt_fb = (cur_pct > 24'(PCT_FULL)) ? PCT_FULL : cur_pct[9:0];
      FB_DCBUS:   nxt_fb = (fbi.dc_volts > DCV_FULL) ? PCT_FULL : fbi.dc_volts[9:0];
      FB_DIFF:    nxt_fb = (fbi.ain1 > fbi.ain2) ? 10'(fbi.ain1 - fbi.ain2) : 10'h000;
      FB_LARGER:  nxt_fb = (fbi.ain1 > fbi.ain2) ? fbi.ain1 : fbi.ain2;
      default:    nxt_fb = fbi.ain2;
    endcase
    // everything ends up on the same 0..1000 scale
    if (nxt_fb > PCT_FULL)
    begin
      nxt_fb = PCT_FULL;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fb_ff <= 10'h000;
    end
    else
    begin
      fb_ff <= nxt_fb;
    end
  end

  assign fbi.fb = fb_ff;
endmodule

// ---- testbench/pic_drive_model.sv ----
// drive speed path model: reports minimum speed back to the controller
`timescale 1ns/100ps
module pic_drive_model
(
  input  wire logic       core_clk,     // system clock
  input  wire logic       resetn,       // async reset, active low
  input  wire logic [9:0] speed_demand, // demand from the controller
  output logic            at_min_speed  // drive settled at minimum speed
);
  logic nxt_min;
  logic min_ff;
  // a real drive needs time to ramp down, so the flag lags the demand by a cycle
  always_comb
  begin
    nxt_min = (speed_demand == 10'h000);
  end
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      min_ff <= 1'b0;
    else
      min_ff <= nxt_min;
  end
  assign at_min_speed = min_ff;
endmodule

// ---- testbench/pic_ctrl_asserts.sv ----
// concurrent checks on the process controller ports
`timescale 1ns/100ps
module pic_ctrl_asserts
#(
  parameter int SAMPLE_CYCLES = 20            // loop period in clocks
)
(
  input wire logic       core_clk,           // system clock
  input wire logic       resetn,             // async reset, active low
  input wire logic [9:0] ain1_level,         // analog input 1
  input wire logic [9:0] ain2_level,         // analog input 2
  input wire logic       at_min_speed,       // drive at minimum speed
  input wire logic [9:0] speed_demand,       // controller output
  input wire logic       motor_enable,       // motor output allowed
  input wire logic       standby,            // drive in standby
  input wire logic [9:0] feedback_level,     // selected feedback
  input wire logic [9:0] ain1_level_readout, // input 1 readout
  input wire logic [9:0] ain2_level_readout  // input 2 readout
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // demand moves only on loop ticks; holds only while SAMPLE_CYCLES exceeds 8
  sequence s_demand_step;
    $changed(speed_demand);
  endsequence
  sequence s_demand_quiet;
    $stable(speed_demand) [*8];
  endsequence
  chk_demand_hold: assert property (s_demand_step |=> s_demand_quiet)
    else $error("speed demand moved between loop ticks");
  chk_readout_one: assert property ($past(resetn) |-> ain1_level_readout == $past(ain1_level))
    else $error("input 1 readout does not follow the input");
  chk_readout_two: assert property ($past(resetn) |-> ain2_level_readout == $past(ain2_level))
    else $error("input 2 readout does not follow the input");
  chk_standby_inverse: assert property (standby == !motor_enable)
    else $error("standby and motor enable disagree");
  chk_demand_range: assert property (speed_demand <= 10'h3E8)
    else $error("speed demand above full scale");
  chk_fb_range: assert property (feedback_level <= 10'h3E8)
    else $error("feedback above full scale");
  chk_standby_cause: assert property ($rose(standby) |-> $past(at_min_speed))
    else $error("standby entered away from minimum speed");
  chk_reset_values: assert property (
    disable iff (1'b0) !resetn |-> speed_demand == 10'h000 && motor_enable && !standby)
    else $error("outputs wrong during reset");
endmodule
bind pic_ctrl pic_ctrl_asserts #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_pic_ctrl_asserts (.core_clk(core_clk),
  .resetn(resetn), .ain1_level(ain1_level), .ain2_level(ain2_level), .at_min_speed(at_min_speed),
  .speed_demand(speed_demand), .motor_enable(motor_enable), .standby(standby), .feedback_level(feedback_level),
  .ain1_level_readout(ain1_level_readout), .ain2_level_readout(ain2_level_readout));

// ---- testbench/pic_ctrl_bench.sv ----
// self-checking bench for the process controller
`timescale 1ns/100ps
module pic_ctrl_bench;
  import pic_pkg::*;
  typedef struct packed {
    logic [8:0]  gain;
    logic [1:0]  mode;
    logic [1:0]  sp;
    logic [9:0]  preset;
    logic [2:0]  fb;
    logic [9:0]  a1;
    logic [9:0]  a2;
    logic [10:0] dcv;
    logic [15:0] bus;
    logic [9:0]  efb;
    logic [9:0]  edem;
  } pic_row_t;
  logic        core_clk, resetn, settings_load, at_min_speed, motor_enable, standby;
  logic [9:0]  ain1_level, ain2_level, digital_preset, wake_level, speed_demand, feedback_level;
  logic [9:0]  ain1_level_readout, ain2_level_readout;
  logic [11:0] motor_current, motor_rated_current;
  logic [10:0] dc_bus_volts;
  logic [15:0] fieldbus_process_word_two;
  logic [8:0]  pi_gain, pi_integral_time;
  logic [1:0]  pi_mode, sp_source;
  logic [2:0]  fb_source;
  logic [7:0]  standby_time;
  pic_row_t    rows [14];
  pic_row_t    r;
  int          errors, check_count, cycles, n;
  pic_ctrl #(.SAMPLE_CYCLES(20)) u_pic_ctrl (.core_clk(core_clk), .resetn(resetn), .ain1_level(ain1_level),
    .ain2_level(ain2_level), .motor_current(motor_current), .motor_rated_current(motor_rated_current),
    .dc_bus_volts(dc_bus_volts), .fieldbus_process_word_two(fieldbus_process_word_two),
    .settings_load(settings_load), .pi_gain(pi_gain), .pi_integral_time(pi_integral_time), .pi_mode(pi_mode),
    .sp_source(sp_source), .digital_preset(digital_preset), .fb_source(fb_source), .standby_time(standby_time),
    .wake_level(wake_level), .at_min_speed(at_min_speed), .speed_demand(speed_demand),
    .motor_enable(motor_enable), .standby(standby), .feedback_level(feedback_level),
    .ain1_level_readout(ain1_level_readout), .ain2_level_readout(ain2_level_readout));
  pic_drive_model u_pic_drive_model (.core_clk(core_clk), .resetn(resetn), .speed_demand(speed_demand),
    .at_min_speed(at_min_speed));
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // settings are copied on the rising edge, so the pulse spans one full cycle
  task automatic load();
    settings_load = 1'b1;
    @(negedge core_clk);
    settings_load = 1'b0;
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    cycles = 0;
    forever
    begin
      @(posedge core_clk);
      cycles = cycles + 1;
      if (cycles == 12000)
      begin
        errors = errors + 1;
        close_out();
      end
    end
  end
  initial
  begin
    {settings_load, pi_gain, pi_integral_time, pi_mode, sp_source, digital_preset, fb_source} = '0;
    {ain1_level, ain2_level, dc_bus_volts, fieldbus_process_word_two, standby_time} = '0;
    {motor_current, motor_rated_current, wake_level} = {12'h032, 12'h0C8, 10'h032};
    {errors, check_count} = '0;
    resetn = 1'b1;
    rows = '{'{9'h00A, 2'h1, 2'h0, 10'h000, 3'h0, 10'h12C, 10'h2BC, 11'h000, 16'h0000, 10'h2BC, 10'h2BC},
             '{9'h00A, 2'h1, 2'h0, 10'h000, 3'h1, 10'h12C, 10'h2BC, 11'h000, 16'h0000, 10'h12C, 10'h12C},
             '{9'h00A, 2'h1, 2'h0, 10'h000, 3'h2, 10'h12C, 10'h2BC, 11'h000, 16'h0000, 10'h0FA, 10'h0FA},
             '{9'h00A, 2'h1, 2'h0, 10'h000, 3'h3, 10'h12C, 10'h2BC, 11'h5DC, 16'h0000, 10'h3E8, 10'h3E8},
             '{9'h00A, 2'h1, 2'h0, 10'h000, 3'h4, 10'h12C, 10'h2BC, 11'h000, 16'h0000, 10'h000, 10'h000},
             '{9'h00A, 2'h1, 2'h0, 10'h000, 3'h4, 10'h384, 10'h0C8, 11'h000, 16'h0000, 10'h2BC, 10'h2BC},
             '{9'h00A, 2'h1, 2'h0, 10'h000, 3'h5, 10'h12C, 10'h2BC, 11'h000, 16'h0000, 10'h2BC, 10'h2BC},
             '{9'h00A, 2'h2, 2'h0, 10'h258, 3'h0, 10'h12C, 10'h0C8, 11'h000, 16'h0000, 10'h0C8, 10'h190},
             '{9'h014, 2'h0, 2'h0, 10'h258, 3'h0, 10'h12C, 10'h0C8, 11'h000, 16'h0000, 10'h0C8, 10'h320},
             '{9'h00A, 2'h0, 2'h1, 10'h258, 3'h0, 10'h1F4, 10'h0C8, 11'h000, 16'h0000, 10'h0C8, 10'h12C},
             '{9'h00A, 2'h0, 2'h2, 10'h258, 3'h0, 10'h12C, 10'h0C8, 11'h000, 16'h0384, 10'h0C8, 10'h2BC},
             '{9'h00A, 2'h0, 2'h2, 10'h000, 3'h0, 10'h12C, 10'h0C8, 11'h000, 16'h1388, 10'h0C8, 10'h320},
             '{9'h00A, 2'h1, 2'h0, 10'h258, 3'h0, 10'h12C, 10'h0C8, 11'h000, 16'h0000, 10'h0C8, 10'h000},
             '{9'h01E, 2'h0, 2'h0, 10'h258, 3'h0, 10'h12C, 10'h0C8, 11'h000, 16'h0000, 10'h0C8, 10'h3E8}};
    // a real falling edge once every flop waits on it, well before the first clock edge
    #1 resetn = 1'b0;
    repeat (12) @(negedge core_clk);
    resetn = 1'b1;
    foreach (rows[i])
    begin
      r = rows[i];
      {pi_gain, pi_mode, sp_source, digital_preset, fb_source} = {r.gain, r.mode, r.sp, r.preset, r.fb};
      {ain1_level, ain2_level, dc_bus_volts, fieldbus_process_word_two} = {r.a1, r.a2, r.dcv, r.bus};
      load();
      repeat (45) @(negedge core_clk);
      check(feedback_level, r.efb);
      check(speed_demand, r.edem);
      check(ain1_level_readout, r.a1);
      check(ain2_level_readout, r.a2);
    end
    // second reset in mid-run, from full demand
    resetn = 1'b0;
    @(negedge core_clk);
    check(speed_demand, 10'h000);
    check({9'h000, motor_enable}, 10'h001);
    check(ain1_level_readout, 10'h000);
    resetn = 1'b1;
    repeat (45) @(negedge core_clk);
    check(feedback_level, 10'h0C8);
    check({9'h000, standby}, 10'h000);
    {pi_gain, pi_integral_time, pi_mode, digital_preset} = {9'h00A, 9'h00A, 2'h0, 10'h12C};
    load();
    repeat (2000) @(negedge core_clk);
    check({9'h000, speed_demand >= 10'h069 && speed_demand <= 10'h070}, 10'h001);
    {pi_integral_time, pi_mode, digital_preset, standby_time} = {9'h000, 2'h3, 10'h1F4, 8'h01};
    ain2_level = 10'h000;
    load();
    n = 0;
    while (standby !== 1'b1 && n < 4000)
    begin
      @(negedge core_clk);
      n = n + 1;
    end
    check({9'h000, n >= 1900 && n <= 2100}, 10'h001);
    check({9'h000, motor_enable}, 10'h000);
    ain2_level = 10'h212;
    repeat (60) @(negedge core_clk);
    check({9'h000, standby}, 10'h001);
    ain2_level = 10'h258;
    repeat (30) @(negedge core_clk);
    check({9'h000, standby}, 10'h000);
    check(speed_demand, 10'h3E8);
    close_out();
  end
endmodule
